// ===== hdl/sfg_guard.sv
// shared flash guard: controller-side control, semaphore and override logic
`timescale 1ns/1ps
module sfg_guard (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic host_rst_i,
    // controller register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // boot block size, low 8K blocks held read only
    input wire logic [4:0] boot_blocks_i,
    // host side
    input wire logic host_sem_we_i,
    input wire logic [3:0] host_sem_wdata_i,
    output logic [7:0] sem_o,
    input wire sfg_pkg::sfg_host_req_t host_req_i,
    output sfg_pkg::sfg_host_rsp_t host_rsp_o,
    // interrupts
    output logic sem_irq_o,
    output logic err_irq_o
);
    // =========================================
    // state
    typedef struct packed {
        logic sem_ie;
        logic sem_wf;
        logic wr_allow;
        logic [1:0] resp_mode;
        logic err_ie;
        logic wr_err;
        logic rd_err;
        logic [sfg_pkg::NREG-1:0][7:0] rd_ovr;
        logic [sfg_pkg::NREG-1:0][7:0] wr_ovr;
        logic [7:0] rdata;
        logic sem_irq;
        logic err_irq;
        sfg_pkg::sfg_host_rsp_t rsp;
    } sfg_state_t;

    sfg_state_t st;
    sfg_state_t next_st;
    logic [7:0] sem;

    // =========================================
    // functions
    // bits software may change in override register k
    function automatic logic [7:0] sfg_wmask(input int k, input logic [4:0] boot);
        logic [7:0] m;
        m = 8'hFF;
        if (k == sfg_pkg::UP0_REG) begin
            m = sfg_pkg::UP0_MASK;
        end
        if (k < sfg_pkg::UP0_REG) begin
            for (int b = 0; b < 8; b++) begin
                m[b] = (5'((k * 8) + b) >= boot);
            end
        end
        return m;
    endfunction : sfg_wmask

    // override bit governing a flash address
    function automatic logic sfg_ovr(input logic [sfg_pkg::NREG-1:0][7:0] r,
                                     input logic [sfg_pkg::ADDR_W-1:0] a);
        logic [79:0] f;
        f = r;
        if (a[sfg_pkg::ADDR_W-1:17] == sfg_pkg::LOW_LIMIT_HI) begin
            return f[a[16:13]];
        end
        return f[7'(16) + 7'(a[sfg_pkg::ADDR_W-1:16])];
    endfunction : sfg_ovr

    // answer to a protected access
    function automatic sfg_pkg::sfg_rsp_kind_t sfg_resp(input logic [1:0] mode, input logic wr);
        case (mode)
            sfg_pkg::MODE_WAIT: return wr ? sfg_pkg::RSP_IGNORE : sfg_pkg::RSP_LONG_WAIT;
            sfg_pkg::MODE_ZERO: return wr ? sfg_pkg::RSP_IGNORE : sfg_pkg::RSP_ZERO;
            sfg_pkg::MODE_ERR: return sfg_pkg::RSP_ERR_SYNC;
            sfg_pkg::MODE_MIX: return wr ? sfg_pkg::RSP_ERR_SYNC : sfg_pkg::RSP_LONG_SYNC;
            default: return sfg_pkg::RSP_ERR_SYNC;
        endcase
    endfunction : sfg_resp

    // =========================================
    // next state
    logic ctrl_wr;
    logic rd_block;
    logic wr_block;
    logic rd_hit;
    logic wr_hit;

    always_comb begin
        next_st = st;
        ctrl_wr = reg_wr_i && (reg_addr_i == sfg_pkg::OFF_CTRL);
        rd_block = host_req_i.prot || sfg_ovr(st.rd_ovr, host_req_i.addr);
        wr_block = host_req_i.prot || sfg_ovr(st.wr_ovr, host_req_i.addr);
        rd_hit = host_req_i.valid && !host_req_i.write && rd_block;
        wr_hit = host_req_i.valid && host_req_i.write && wr_block;
        // control register, set wins over clear
        if (ctrl_wr) begin
            next_st.sem_ie = reg_wdata_i[sfg_pkg::B_SEM_IE];
            next_st.wr_allow = reg_wdata_i[sfg_pkg::B_WR_ALLOW];
            next_st.resp_mode = reg_wdata_i[sfg_pkg::B_RESP_HI:sfg_pkg::B_RESP_LO];
            next_st.err_ie = reg_wdata_i[sfg_pkg::B_ERR_IE];
            if (reg_wdata_i[sfg_pkg::B_SEM_WF]) begin
                next_st.sem_wf = 1'b0;
            end
            if (reg_wdata_i[sfg_pkg::B_WR_ERR]) begin
                next_st.wr_err = 1'b0;
            end
            if (reg_wdata_i[sfg_pkg::B_RD_ERR]) begin
                next_st.rd_err = 1'b0;
            end
        end
        if (host_sem_we_i) begin
            next_st.sem_wf = 1'b1;
        end
        if (wr_hit) begin
            next_st.wr_err = 1'b1;
        end
        if (rd_hit) begin
            next_st.rd_err = 1'b1;
        end
        // override registers, controller port only
        for (int k = 0; k < sfg_pkg::NREG; k++) begin
            if (reg_wr_i && (reg_addr_i == sfg_pkg::OFF_RD[k])) begin
                next_st.rd_ovr[k] = (st.rd_ovr[k] & ~sfg_wmask(k, boot_blocks_i))
                                  | (reg_wdata_i & sfg_wmask(k, boot_blocks_i));
            end
            if (reg_wr_i && (reg_addr_i == sfg_pkg::OFF_WR[k])) begin
                next_st.wr_ovr[k] = (st.wr_ovr[k] & ~sfg_wmask(k, boot_blocks_i))
                                  | (reg_wdata_i & sfg_wmask(k, boot_blocks_i));
            end
        end
        // read data, one cycle after the strobe only
        next_st.rdata = 8'h00;
        if (reg_rd_i) begin
            if (reg_addr_i == sfg_pkg::OFF_CTRL) begin
                next_st.rdata = {st.sem_ie, st.sem_wf, st.wr_allow, st.resp_mode, st.err_ie, st.wr_err, st.rd_err};
            end
            if (reg_addr_i == sfg_pkg::OFF_SEM) begin
                next_st.rdata = sem;
            end
            for (int k = 0; k < sfg_pkg::NREG; k++) begin
                if (reg_addr_i == sfg_pkg::OFF_RD[k]) begin
                    next_st.rdata = st.rd_ovr[k];
                end
                if (reg_addr_i == sfg_pkg::OFF_WR[k]) begin
                    next_st.rdata = st.wr_ovr[k];
                end
            end
        end
        // host access answer
        next_st.rsp.valid = host_req_i.valid;
        next_st.rsp.mbus_rd = 1'b0;
        next_st.rsp.mbus_wr = 1'b0;
        next_st.rsp.kind = sfg_pkg::RSP_OK;
        if (host_req_i.valid) begin
            if (host_req_i.write) begin
                if (wr_block) begin
                    next_st.rsp.kind = sfg_resp(st.resp_mode, 1'b1);
                end else if (!st.wr_allow) begin
                    next_st.rsp.kind = sfg_pkg::RSP_IGNORE;
                end else begin
                    next_st.rsp.mbus_wr = 1'b1;
                end
            end else begin
                if (rd_block) begin
                    next_st.rsp.kind = sfg_resp(st.resp_mode, 1'b0);
                end else begin
                    next_st.rsp.mbus_rd = 1'b1;
                end
            end
        end
        // level interrupts from the new flag and enable values
        next_st.sem_irq = next_st.sem_ie && next_st.sem_wf;
        next_st.err_irq = next_st.err_ie && (next_st.wr_err || next_st.rd_err);
    end

    // =========================================
    // registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.resp_mode <= sfg_pkg::RESP_RST;
            st.rd_ovr <= {sfg_pkg::NREG{sfg_pkg::RD_OVR_RST}};
            st.wr_ovr <= {sfg_pkg::NREG{sfg_pkg::WR_OVR_RST}};
            st.wr_ovr[sfg_pkg::UP0_REG] <= sfg_pkg::WR_OVR_RST & sfg_pkg::UP0_MASK;
        end else begin
            st <= next_st;
        end
    end

    // semaphore lives in the host reset domain, untouched by controller reset
    always_ff @(posedge clk_i) begin
        if (host_rst_i) begin
            sem <= 8'h00;
        end else begin
            if (reg_wr_i && (reg_addr_i == sfg_pkg::OFF_SEM)) begin
                sem[7:4] <= reg_wdata_i[7:4];
            end
            if (host_sem_we_i) begin
                sem[3:0] <= host_sem_wdata_i;
            end
        end
    end

    // =========================================
    // outputs
    assign reg_rdata_o = st.rdata;
    assign sem_o = sem;
    assign host_rsp_o = st.rsp;
    assign sem_irq_o = st.sem_irq;
    assign err_irq_o = st.err_irq;

    // =========================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_ctrl_wr(int b);
        reg_wr_i && reg_addr_i == sfg_pkg::OFF_CTRL && reg_wdata_i[b];
    endsequence

    property p_sem_irq;
        st.sem_ie && st.sem_wf |-> sem_irq_o;
    endproperty
    a_sem_irq: assert property (p_sem_irq) else $error("semaphore irq missing");

    property p_sem_flag;
        host_sem_we_i |=> st.sem_wf && sem[3:0] == $past(host_sem_wdata_i);
    endproperty
    a_sem_flag: assert property (p_sem_flag) else $error("semaphore flag not set");

    property p_no_write;
        host_rsp_o.mbus_wr |-> $past(st.wr_allow);
    endproperty
    a_no_write: assert property (p_no_write) else $error("write issued while not allowed");

    property p_zero_mode;
        host_req_i.valid && !host_req_i.write && rd_block && st.resp_mode == sfg_pkg::MODE_ZERO
            |=> host_rsp_o.kind == sfg_pkg::RSP_ZERO && !host_rsp_o.mbus_rd;
    endproperty
    a_zero_mode: assert property (p_zero_mode) else $error("wrong protected read answer");

    property p_err_irq;
        st.err_ie && (st.wr_err || st.rd_err) |-> err_irq_o;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("error irq missing");

    property p_wr_err;
        wr_hit |=> st.wr_err ##1 (st.wr_err || $past(ctrl_wr && reg_wdata_i[sfg_pkg::B_WR_ERR]));
    endproperty
    a_wr_err: assert property (p_wr_err) else $error("write error not flagged");

    property p_rd_err;
        rd_hit |=> st.rd_err;
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("read error not flagged");

    property p_host_nibble;
        !host_sem_we_i && !host_rst_i |=> sem[3:0] == $past(sem[3:0]);
    endproperty
    a_host_nibble: assert property (p_host_nibble) else $error("host nibble changed by controller");

    property p_sem_rst;
        host_rst_i |=> sem == 8'h00;
    endproperty
    a_sem_rst: assert property (p_sem_rst) else $error("semaphore not cleared");

    property p_rd_gate;
        host_rsp_o.mbus_rd |-> $past(!rd_block && host_req_i.valid);
    endproperty
    a_rd_gate: assert property (p_rd_gate) else $error("blocked read issued");

    property p_reserved;
        st.rd_ovr[sfg_pkg::UP0_REG][1:0] == 2'h0 && st.wr_ovr[sfg_pkg::UP0_REG][1:0] == 2'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved override bits set");

    property p_irq_drop;
        !st.sem_ie || !st.sem_wf |-> !sem_irq_o;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("semaphore irq stuck");

    property p_wr_clear;
        s_ctrl_wr(sfg_pkg::B_WR_ERR) ##0 !wr_hit |=> !st.wr_err;
    endproperty
    a_wr_clear: assert property (p_wr_clear) else $error("write error not cleared");

    property p_rd_clear;
        s_ctrl_wr(sfg_pkg::B_RD_ERR) ##0 !rd_hit |=> !st.rd_err;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("read error not cleared");

    property p_sem_clear;
        s_ctrl_wr(sfg_pkg::B_SEM_WF) ##0 !host_sem_we_i |=> !st.sem_wf;
    endproperty
    a_sem_clear: assert property (p_sem_clear) else $error("semaphore flag not cleared");

    property p_wr_gate;
        host_rsp_o.mbus_wr |-> $past(host_req_i.valid && host_req_i.write && !wr_block);
    endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("blocked write issued");

    property p_rsp_valid;
        host_req_i.valid |=> host_rsp_o.valid;
    endproperty
    a_rsp_valid: assert property (p_rsp_valid) else $error("host access not answered");

    property p_err_drop;
        !st.err_ie || !(st.wr_err || st.rd_err) |-> !err_irq_o;
    endproperty
    a_err_drop: assert property (p_err_drop) else $error("error irq stuck");

    property p_ctrl_nibble;
        reg_wr_i && reg_addr_i == sfg_pkg::OFF_SEM && !host_rst_i |=> sem[7:4] == $past(reg_wdata_i[7:4]);
    endproperty
    a_ctrl_nibble: assert property (p_ctrl_nibble) else $error("controller nibble not written");

    property p_boot_ro;
        reg_wr_i && reg_addr_i == sfg_pkg::OFF_RD[0] && boot_blocks_i != 5'h00
            |=> st.rd_ovr[0][0] == $past(st.rd_ovr[0][0]);
    endproperty
    a_boot_ro: assert property (p_boot_ro) else $error("boot block override bit changed");

endmodule : sfg_guard

// ===== hdl/sfg_pkg.sv
// shared flash guard: constants and carrier types
package sfg_pkg;
    // =========================================
    // sizes
    localparam int ADDR_W = 22;
    localparam int NREG = 10;
    // =========================================
    // register offsets
    localparam logic [7:0] OFF_CTRL = 8'h20;
    localparam logic [7:0] OFF_SEM = 8'h22;
    localparam logic [7:0] OFF_RD [NREG] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h11, 8'h12, 8'h13, 8'h14};
    localparam logic [7:0] OFF_WR [NREG] = '{8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h15, 8'h16, 8'h17, 8'h18};
    // =========================================
    // control field positions
    localparam int B_SEM_IE = 7;
    localparam int B_SEM_WF = 6;
    localparam int B_WR_ALLOW = 5;
    localparam int B_RESP_HI = 4;
    localparam int B_RESP_LO = 3;
    localparam int B_ERR_IE = 2;
    localparam int B_WR_ERR = 1;
    localparam int B_RD_ERR = 0;
    // =========================================
    // reset values and masks
    localparam logic [7:0] RD_OVR_RST = 8'h00;
    localparam logic [7:0] WR_OVR_RST = 8'hFF;
    localparam logic [7:0] UP0_MASK = 8'hFC;
    localparam int UP0_REG = 2;
    localparam logic [1:0] RESP_RST = 2'h0;
    localparam logic [4:0] LOW_LIMIT_HI = 5'h00;
    // =========================================
    // error response modes
    localparam logic [1:0] MODE_WAIT = 2'h0;
    localparam logic [1:0] MODE_ZERO = 2'h1;
    localparam logic [1:0] MODE_ERR = 2'h2;
    localparam logic [1:0] MODE_MIX = 2'h3;
    // =========================================
    // types
    typedef enum logic [2:0] {
        RSP_OK,
        RSP_LONG_WAIT,
        RSP_ZERO,
        RSP_ERR_SYNC,
        RSP_LONG_SYNC,
        RSP_IGNORE
    } sfg_rsp_kind_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic prot;
        logic [ADDR_W-1:0] addr;
    } sfg_host_req_t;

    typedef struct packed {
        logic valid;
        logic mbus_rd;
        logic mbus_wr;
        sfg_rsp_kind_t kind;
    } sfg_host_rsp_t;
endpackage : sfg_pkg

// ===== tb/sfg_host_model.sv
// host processor model: flash accesses and semaphore nibble writes
`timescale 1ns/1ps
module sfg_host_model (
    // clock
    input wire logic clk_i,
    // flash access
    output sfg_pkg::sfg_host_req_t req_o,
    input wire sfg_pkg::sfg_host_rsp_t rsp_i,
    // semaphore nibble
    output logic sem_we_o,
    output logic [3:0] sem_wdata_o
);
    // =========================================
    // idle state, no register port on this side
    initial begin
        req_o = '0;
        sem_we_o = 1'b0;
        sem_wdata_o = 4'h0;
    end
    // =========================================
    // one access, answer taken one cycle later
    task automatic access(input logic w, input logic p, input logic [21:0] a,
                          output sfg_pkg::sfg_host_rsp_t r);
        @(posedge clk_i);
        req_o <= '{valid: 1'b1, write: w, prot: p, addr: a};
        @(posedge clk_i);
        req_o <= '{valid: 1'b0, write: ~w, prot: ~p, addr: ~a};
        #1 r = rsp_i;
    endtask : access
    // =========================================
    // host nibble write, data inverted on release
    task automatic sem_write(input logic [3:0] d);
        @(posedge clk_i);
        sem_we_o <= 1'b1;
        sem_wdata_o <= d;
        @(posedge clk_i);
        sem_we_o <= 1'b0;
        sem_wdata_o <= ~d;
        #1;
    endtask : sem_write
endmodule : sfg_host_model

// ===== tb/testbench.sv
// self-checking testbench for the shared flash guard
`timescale 1ns/1ps
module testbench;
    // =========================================
    // signals
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic host_rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [4:0] boot = 5'h00;
    logic [7:0] rdata;
    logic [7:0] sem;
    logic sem_irq;
    logic err_irq;
    logic sem_we;
    logic [3:0] sem_wd;
    sfg_pkg::sfg_host_req_t req;
    sfg_pkg::sfg_host_rsp_t rsp;
    int fails = 0;
    int tests_run = 0;
    sfg_pkg::sfg_rsp_kind_t rk [4] = '{sfg_pkg::RSP_LONG_WAIT, sfg_pkg::RSP_ZERO,
                                       sfg_pkg::RSP_ERR_SYNC, sfg_pkg::RSP_LONG_SYNC};
    sfg_pkg::sfg_rsp_kind_t wk [4] = '{sfg_pkg::RSP_IGNORE, sfg_pkg::RSP_IGNORE,
                                       sfg_pkg::RSP_ERR_SYNC, sfg_pkg::RSP_ERR_SYNC};
    // =========================================
    // design and host model
    sfg_guard uut (.clk_i(clock_i), .rst_n_i(rst_n_i), .host_rst_i(host_rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .boot_blocks_i(boot), .host_sem_we_i(sem_we),
        .host_sem_wdata_i(sem_wd), .sem_o(sem), .host_req_i(req), .host_rsp_o(rsp),
        .sem_irq_o(sem_irq), .err_irq_o(err_irq));
    sfg_host_model host (.clk_i(clock_i), .req_o(req), .rsp_i(rsp),
        .sem_we_o(sem_we), .sem_wdata_o(sem_wd));
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    // =========================================
    // compares and bus cycles
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chkr(input sfg_pkg::sfg_host_rsp_t got, input logic [1:0] bus,
                        input sfg_pkg::sfg_rsp_kind_t k);
        tests_run++;
        if (got !== {1'b1, bus, k}) begin
            fails++;
            $display("ERROR %0t: response %h expected %h", $time, got, {1'b1, bus, k});
        end
    endtask : chkr
    task automatic chk_irq(input logic s, input logic e);
        #1 chk8({6'h00, sem_irq, err_irq}, {6'h00, s, e});
    endtask : chk_irq
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1 chk8(rdata, exp);
    endtask : rreg
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    // =========================================
    // scenarios
    task automatic t_reset();
        for (int i = 0; i < sfg_pkg::NREG; i++) begin
            rreg(sfg_pkg::OFF_RD[i], 8'h00);
            rreg(sfg_pkg::OFF_WR[i], (i == 2) ? 8'hFC : 8'hFF);
            wreg(sfg_pkg::OFF_RD[i], 8'hA7);
            rreg(sfg_pkg::OFF_RD[i], (i == 2) ? 8'hA4 : 8'hA7);
            wreg(sfg_pkg::OFF_RD[i], 8'h00);
        end
        rreg(sfg_pkg::OFF_CTRL, 8'h00);
        rreg(8'h00, 8'h00);
        @(posedge clock_i);
        boot <= 5'h02;
        wreg(sfg_pkg::OFF_RD[0], 8'hFF);
        rreg(sfg_pkg::OFF_RD[0], 8'hFC);
        wreg(sfg_pkg::OFF_RD[0], 8'h00);
        boot <= 5'h00;
    endtask : t_reset
    task automatic t_sem();
        host.sem_write(4'h5);
        chk8(sem, 8'h05);
        chk_irq(1'b0, 1'b0);
        rreg(sfg_pkg::OFF_CTRL, 8'h40);
        wreg(sfg_pkg::OFF_CTRL, 8'h80);
        chk_irq(1'b1, 1'b0);
        wreg(sfg_pkg::OFF_SEM, 8'hAF);
        rreg(sfg_pkg::OFF_SEM, 8'hA5);
        chk8(sem, 8'hA5);
        wreg(sfg_pkg::OFF_CTRL, 8'hC0);
        chk_irq(1'b0, 1'b0);
        rreg(sfg_pkg::OFF_CTRL, 8'h80);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        #1 chk8(sem, 8'hA5);
        @(posedge clock_i);
        host_rst_i <= 1'b1;
        @(posedge clock_i);
        host_rst_i <= 1'b0;
        rreg(sfg_pkg::OFF_SEM, 8'h00);
    endtask : t_sem
    task automatic t_prot();
        logic [7:0] base;
        sfg_pkg::sfg_host_rsp_t r;
        wreg(sfg_pkg::OFF_RD[0], 8'h08);
        for (int m = 0; m < 4; m++) begin
            base = 8'h24 | {3'h0, m[1:0], 3'h0};
            wreg(sfg_pkg::OFF_CTRL, base);
            host.access(1'b0, 1'b0, 22'h006000, r);
            chkr(r, 2'h0, rk[m]);
            host.access(1'b1, 1'b0, 22'h008000, r);
            chkr(r, 2'h0, wk[m]);
            chk_irq(1'b0, 1'b1);
            wreg(sfg_pkg::OFF_CTRL, base);
            rreg(sfg_pkg::OFF_CTRL, base | 8'h03);
            wreg(sfg_pkg::OFF_CTRL, base | 8'h03);
            chk_irq(1'b0, 1'b0);
        end
        host.access(1'b0, 1'b0, 22'h005FFF, r);
        chkr(r, 2'h2, sfg_pkg::RSP_OK);
        host.access(1'b0, 1'b1, 22'h010000, r);
        chkr(r, 2'h0, sfg_pkg::RSP_LONG_SYNC);
        wreg(sfg_pkg::OFF_RD[2], 8'h04);
        wreg(sfg_pkg::OFF_RD[9], 8'h80);
        host.access(1'b0, 1'b0, 22'h01FFFF, r);
        chkr(r, 2'h2, sfg_pkg::RSP_OK);
        host.access(1'b0, 1'b0, 22'h020000, r);
        chkr(r, 2'h0, sfg_pkg::RSP_LONG_SYNC);
        host.access(1'b0, 1'b0, 22'h3F0000, r);
        chkr(r, 2'h0, sfg_pkg::RSP_LONG_SYNC);
        wreg(sfg_pkg::OFF_CTRL, 8'h03);
        wreg(sfg_pkg::OFF_WR[1], 8'h00);
        host.access(1'b1, 1'b0, 22'h010000, r);
        chkr(r, 2'h0, sfg_pkg::RSP_IGNORE);
        wreg(sfg_pkg::OFF_CTRL, 8'h20);
        host.access(1'b1, 1'b0, 22'h010000, r);
        chkr(r, 2'h1, sfg_pkg::RSP_OK);
        rreg(sfg_pkg::OFF_CTRL, 8'h20);
    endtask : t_prot
    // =========================================
    // main sequence and watchdog
    initial begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        host_rst_i <= 1'b0;
        t_reset();
        t_sem();
        t_prot();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        fails++;
        $display("ERROR %0t: run did not finish", $time);
        complete_run();
    end
endmodule : testbench
